// ---- common/pacd_cfg.svh ----
// Offsets, field positions, reset values and selector codes of the clock-control block
`ifndef PACD_CFG_SVH
`define PACD_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PACD_OFS_ACC1       8'h84
`define PACD_OFS_ACC2       8'h88
`define PACD_OFS_I3C_SEL    8'hA0
`define PACD_OFS_I3C_DIV    8'hA4
`define PACD_OFS_TMR0_SEL   8'hA8
`define PACD_OFS_TMR0_DIV   8'hAC
`define PACD_OFS_TMR1_SEL   8'hB0
`define PACD_OFS_TMR1_DIV   8'hB4
`define PACD_OFS_TMR2_SEL   8'hB8
`define PACD_OFS_TMR2_DIV   8'hBC

// ****************************************
// Writable masks and reset values
// ****************************************
`define PACD_ACC1_MASK      32'h077F_FFFF
`define PACD_ACC2_MASK      32'h0000_07FE
`define PACD_ACC1_RST       32'h0000_0000
`define PACD_ACC2_RST       32'h0000_040E
`define PACD_SEL_RST        3'h7
`define PACD_DIV_RST        4'h0

// ****************************************
// Field positions
// ****************************************
`define PACD_SEL_MSB        2
`define PACD_DIV_MSB        3
`define PACD_UNSTABLE_BIT   31
`define PACD_HALT_BIT       30
`define PACD_CNTRST_BIT     29

// ****************************************
// Source selector codes
// ****************************************
`define PACD_SEL_LF         3'h0
`define PACD_SEL_HF_GATED   3'h1
`define PACD_SEL_HF_DIV     3'h2
`define PACD_SEL_EXT        3'h3
`define PACD_SEL_16K        3'h4
`define PACD_SEL_1M         3'h5
`define PACD_SEL_PLL        3'h6
`define PACD_SEL_NONE       3'h7

`endif

// ---- common/pacd_pkg.sv ----
// Types of the clock-control block
package pacd_pkg;

	// ****************************************
	// Register bus request
	// ****************************************
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} pacd_bus_req_t;

	// ****************************************
	// Clock sources, sampled as levels
	// ****************************************
	typedef struct packed {
		logic low_freq_osc_divided;
		logic high_freq_osc_gated;
		logic high_freq_osc_divided;
		logic ext_clock_in;
		logic clock_16_khz;
		logic clock_1_mhz;
		logic pll_output_divided;
	} pacd_src_t;

	// ****************************************
	// Divider control fields
	// ****************************************
	typedef struct packed {
		logic       halt;
		logic       cnt_rst;
		logic [3:0] div;
	} pacd_div_ctrl_t;

	// ****************************************
	// Auto-gating register layouts
	// ****************************************
	typedef struct packed {
		logic [4:0] rsv_hi;
		logic       random_generator;
		logic       symmetric_crypto_engine;
		logic       public_key_engine;
		logic       rsv_23;
		logic       uart_five;
		logic       i2c_three;
		logic       i2c_two;
		logic       can_one;
		logic       can_zero;
		logic       segment_lcd;
		logic [4:0] port;
		logic [3:0] amplifier;
		logic       dac_unit;
		logic [2:0] comparator;
		logic [1:0] converter;
		logic       os_timer;
		logic       pwm_one;
	} pacd_acc1_t;

	typedef struct packed {
		logic [20:0] rsv_hi;
		logic        rom_controller;
		logic        math_accelerator;
		logic [4:0]  gpio;
		logic [2:0]  ram_bank;
		logic        rsv_0;
	} pacd_acc2_t;

endpackage : pacd_pkg

// ---- rtl/pacd_divider.sv ----
// Functional clock divider with halt, counter reset and stability flag
`timescale 1ns/1ns
`include "pacd_cfg.svh"

module pacd_divider #(
	parameter int DIV_W = 4
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             src,
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             halt,
	input  wire logic             cnt_rst,
	input  wire logic             restart,
	output logic                  unstable_ff,
	output logic                  clk_out_ff
);

	logic             src_prev_ff;
	logic             halt_prev_ff;
	logic [DIV_W-1:0] cnt_ff;
	logic             src_fall;
	logic             wrap;

	assign src_fall = src_prev_ff & ~src;
	assign wrap     = src_fall & (cnt_ff >= div);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_prev_ff  <= 1'b0;
			halt_prev_ff <= 1'b0;
		end else begin
			src_prev_ff  <= src;
			halt_prev_ff <= halt;
		end
	end

	// Count advances on source falls so the window is steady while the source is high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= '0;
		end else if (cnt_rst || restart) begin
			cnt_ff <= '0;
		end else if (!halt && src_fall) begin
			cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_out_ff <= 1'b0;
		end else if (halt || cnt_rst) begin
			clk_out_ff <= 1'b0;
		end else begin
			clk_out_ff <= src & (cnt_ff == '0);
		end
	end

	// Set wins over the clear that one full period at the new ratio brings
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			unstable_ff <= 1'b0;
		end else if (restart || cnt_rst || (halt_prev_ff && !halt)) begin
			unstable_ff <= 1'b1;
		end else if (!halt && wrap) begin
			unstable_ff <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence seq_restart;
		restart && !cnt_rst;
	endsequence

	sequence seq_flagged;
		##1 unstable_ff && cnt_ff == '0;
	endsequence

	a_restart_flags: assert property (seq_restart |-> seq_flagged)
		else $error("divider restart did not raise unstable flag");
	a_halt_stops: assert property (halt |=> !clk_out_ff)
		else $error("divided clock ran while halted");
	a_cnt_held: assert property (cnt_rst [*2] |-> cnt_ff == '0 && !clk_out_ff)
		else $error("divider counter not held in reset");
	a_bypass_follow: assert property (div == '0 && !halt && !cnt_rst && $stable(div)
			|=> clk_out_ff == $past(src))
		else $error("divide by one does not follow source");

endmodule : pacd_divider

// ---- rtl/pacd_top.sv ----
// Auto-gating enables, functional clock selectors and dividers with register port
`timescale 1ns/1ns
`include "pacd_cfg.svh"

module pacd_top #(
	parameter int DIV_W = 4
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire pacd_pkg::pacd_bus_req_t bus_req,
	output logic [31:0]                 reg_rdata_ff,
	input  wire pacd_pkg::pacd_src_t    src,
	input  wire logic [3:0]             fclk_clk_en,
	input  wire logic [3:0]             fclk_auto_gate,
	input  wire logic [3:0]             fclk_periph_idle,
	output pacd_pkg::pacd_acc1_t        auto_gate_1_ff,
	output pacd_pkg::pacd_acc2_t        auto_gate_2_ff,
	output logic [3:0]                  fclk_ff
);

	// ****************************************
	// Channel map: 0 I3C, 1..3 timers zero..two
	// ****************************************
	localparam int N_CHAN = 4;

	localparam logic [7:0] SEL_OFS [N_CHAN] = '{
		`PACD_OFS_I3C_SEL, `PACD_OFS_TMR0_SEL, `PACD_OFS_TMR1_SEL, `PACD_OFS_TMR2_SEL
	};
	localparam logic [7:0] DIV_OFS [N_CHAN] = '{
		`PACD_OFS_I3C_DIV, `PACD_OFS_TMR0_DIV, `PACD_OFS_TMR1_DIV, `PACD_OFS_TMR2_DIV
	};
	localparam logic [N_CHAN-1:0] IS_TIMER = 4'hE;

	logic [2:0]               sel_ff [N_CHAN];
	pacd_pkg::pacd_div_ctrl_t dctl_ff [N_CHAN];
	logic [N_CHAN-1:0]        src_sel_ff;
	logic [N_CHAN-1:0]        restart;
	logic [N_CHAN-1:0]        div_out;
	logic [N_CHAN-1:0]        divider_unstable_flag;
	logic [31:0]              nxt_rdata;
	logic                     wr_acc1;
	logic                     wr_acc2;

	assign wr_acc1 = bus_req.wr && (bus_req.addr == `PACD_OFS_ACC1);
	assign wr_acc2 = bus_req.wr && (bus_req.addr == `PACD_OFS_ACC2);

	// ****************************************
	// Source decode per channel kind
	// ****************************************
	function automatic logic pick_src(
		input logic                is_timer,
		input logic [2:0]          code,
		input pacd_pkg::pacd_src_t s
	);
		logic v;
		v = 1'b0;
		case (code)
			`PACD_SEL_LF:       v = s.low_freq_osc_divided;
			`PACD_SEL_HF_GATED: v = is_timer & s.high_freq_osc_gated;
			`PACD_SEL_HF_DIV:   v = ~is_timer & s.high_freq_osc_divided;
			`PACD_SEL_EXT:      v = s.ext_clock_in;
			`PACD_SEL_16K:      v = is_timer & s.clock_16_khz;
			`PACD_SEL_1M:       v = s.clock_1_mhz;
			`PACD_SEL_PLL:      v = s.pll_output_divided;
			default:            v = 1'b0;
		endcase
		return v;
	endfunction : pick_src

	// ****************************************
	// Auto-gating registers
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			auto_gate_1_ff <= `PACD_ACC1_RST;
		end else if (wr_acc1) begin
			auto_gate_1_ff <= bus_req.wdata & `PACD_ACC1_MASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			auto_gate_2_ff <= `PACD_ACC2_RST;
		end else if (wr_acc2) begin
			auto_gate_2_ff <= bus_req.wdata & `PACD_ACC2_MASK;
		end
	end

	// ****************************************
	// Per-channel selector, divider and gate
	// ****************************************
	for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
		logic wr_sel;
		logic wr_div;

		assign wr_sel = bus_req.wr && (bus_req.addr == SEL_OFS[i]);
		assign wr_div = bus_req.wr && (bus_req.addr == DIV_OFS[i]);

		// A new source or ratio restarts the count and marks the output unsettled
		assign restart[i] = (wr_sel && bus_req.wdata[`PACD_SEL_MSB:0] != sel_ff[i])
			|| (wr_div && bus_req.wdata[`PACD_DIV_MSB:0] != dctl_ff[i].div);

		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				sel_ff[i] <= `PACD_SEL_RST;
			end else if (wr_sel) begin
				sel_ff[i] <= bus_req.wdata[`PACD_SEL_MSB:0];
			end
		end

		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				dctl_ff[i].halt    <= 1'b0;
				dctl_ff[i].cnt_rst <= 1'b0;
				dctl_ff[i].div     <= `PACD_DIV_RST;
			end else if (wr_div) begin
				dctl_ff[i].halt    <= bus_req.wdata[`PACD_HALT_BIT];
				dctl_ff[i].cnt_rst <= bus_req.wdata[`PACD_CNTRST_BIT];
				dctl_ff[i].div     <= bus_req.wdata[`PACD_DIV_MSB:0];
			end
		end

		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				src_sel_ff[i] <= 1'b0;
			end else begin
				src_sel_ff[i] <= pick_src(IS_TIMER[i], sel_ff[i], src);
			end
		end

		pacd_divider #(
			.DIV_W (DIV_W)
		) u_div (
			.clk        (clk),
			.sys_rst    (sys_rst),
			.src        (src_sel_ff[i]),
			.div        (dctl_ff[i].div),
			.halt       (dctl_ff[i].halt),
			.cnt_rst    (dctl_ff[i].cnt_rst),
			.restart    (restart[i]),
			.unstable_ff (divider_unstable_flag[i]),
			.clk_out_ff (div_out[i])
		);

		// Enable must be on and auto-gating must not be idling the peripheral
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				fclk_ff[i] <= 1'b0;
			end else begin
				fclk_ff[i] <= div_out[i] & fclk_clk_en[i]
					& ~(fclk_auto_gate[i] & fclk_periph_idle[i]);
			end
		end
	end

	// ****************************************
	// Read path, data valid one cycle after strobe
	// ****************************************
	always_comb begin
		nxt_rdata = '0;
		if (bus_req.rd) begin
			if (bus_req.addr == `PACD_OFS_ACC1) begin
				nxt_rdata = auto_gate_1_ff;
			end
			if (bus_req.addr == `PACD_OFS_ACC2) begin
				nxt_rdata = auto_gate_2_ff;
			end
			for (int k = 0; k < N_CHAN; k++) begin
				if (bus_req.addr == SEL_OFS[k]) begin
					nxt_rdata = {29'h0, sel_ff[k]};
				end
				if (bus_req.addr == DIV_OFS[k]) begin
					nxt_rdata = {divider_unstable_flag[k], dctl_ff[k].halt, dctl_ff[k].cnt_rst,
						25'h0, dctl_ff[k].div};
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_ff <= '0;
		end else begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence seq_rd_acc2;
		bus_req.rd && bus_req.addr == `PACD_OFS_ACC2 && !bus_req.wr;
	endsequence

	a_acc1_write: assert property (wr_acc1 |=>
			auto_gate_1_ff == ($past(bus_req.wdata) & `PACD_ACC1_MASK))
		else $error("auto gate 1 write not stored with reserved bits cleared");
	a_acc1_offset: assert property (bus_req.wr && bus_req.addr != `PACD_OFS_ACC1
			|=> $stable(auto_gate_1_ff))
		else $error("auto gate 1 changed by write to another offset");
	a_acc2_rsv_zero: assert property (seq_rd_acc2 |=>
			reg_rdata_ff[31:11] == 21'h0 && reg_rdata_ff[0] == 1'b0)
		else $error("auto gate 2 reserved bits read nonzero");
	a_rdata_sel: assert property (bus_req.rd && bus_req.addr == `PACD_OFS_TMR1_SEL
			|=> reg_rdata_ff == {29'h0, $past(sel_ff[2])})
		else $error("selector read data wrong");
	a_tmr1_reset: assert property ($fell(sys_rst) |-> sel_ff[2] == `PACD_SEL_NONE)
		else $error("timer one selector not no clock after reset");
	a_i3c_none: assert property (sel_ff[0] == `PACD_SEL_NONE
			|=> !src_sel_ff[0])
		else $error("i3c no-clock code passed a source");
	a_i3c_16k_blocked: assert property (sel_ff[0] == `PACD_SEL_16K
			|=> !src_sel_ff[0])
		else $error("i3c unlisted code passed a source");
	a_tmr_16k: assert property (sel_ff[1] == `PACD_SEL_16K
			|=> src_sel_ff[1] == $past(src.clock_16_khz))
		else $error("timer zero did not pick 16 kHz source");
	a_fclk_gate: assert property (!fclk_clk_en[3] |=> !fclk_ff[3])
		else $error("functional clock ran with enable low");
	a_unstable_read: assert property (bus_req.wr && bus_req.addr == `PACD_OFS_I3C_DIV
			&& bus_req.wdata[`PACD_DIV_MSB:0] != dctl_ff[0].div
			##1 bus_req.rd && bus_req.addr == `PACD_OFS_I3C_DIV
			|=> reg_rdata_ff[`PACD_UNSTABLE_BIT])
		else $error("divider change not reported as unstable");

endmodule : pacd_top

// ---- verif/pacd_src_model.sv ----
// Free-running source clocks that feed the functional clock selectors
`timescale 1ns/1ns

module pacd_src_model (
	input  wire logic           clk,
	input  wire logic           sys_rst,
	output pacd_pkg::pacd_src_t src
);
	// ****************************************
	// Half periods in clk cycles, in selector-code order
	// ****************************************
	localparam int HALF [7] = '{2, 3, 4, 5, 6, 8, 10};

	logic [6:0] lvl_ff;
	int         cnt_ff [7];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lvl_ff <= 7'h00;
			for (int i = 0; i < 7; i++) begin
				cnt_ff[i] <= 0;
			end
		end else begin
			for (int i = 0; i < 7; i++) begin
				if (cnt_ff[i] == HALF[i] - 1) begin
					cnt_ff[i] <= 0;
					lvl_ff[i] <= ~lvl_ff[i];
				end else begin
					cnt_ff[i] <= cnt_ff[i] + 1;
				end
			end
		end
	end

	assign src.low_freq_osc_divided  = lvl_ff[0];
	assign src.high_freq_osc_gated   = lvl_ff[1];
	assign src.high_freq_osc_divided = lvl_ff[2];
	assign src.ext_clock_in          = lvl_ff[3];
	assign src.clock_16_khz          = lvl_ff[4];
	assign src.clock_1_mhz           = lvl_ff[5];
	assign src.pll_output_divided    = lvl_ff[6];
endmodule : pacd_src_model

// ---- verif/testbench.sv ----
// Self-checking bench for the auto-gating, selector and divider block
`timescale 1ns/1ns

module testbench;
	// ****************************************
	// Signals
	// ****************************************
	typedef struct {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] e;
	} pacd_tb_row_t;

	logic                    clk;
	logic                    sys_rst;
	pacd_pkg::pacd_bus_req_t bus_req;
	logic [31:0]             reg_rdata_ff;
	pacd_pkg::pacd_src_t     src;
	logic [3:0]              clk_en;
	logic [3:0]              auto_gate;
	logic [3:0]              idle;
	pacd_pkg::pacd_acc1_t    ag1;
	pacd_pkg::pacd_acc2_t    ag2;
	logic [3:0]              fclk;
	int                      err_count;
	int                      comparisons;
	logic [31:0]             rd_val;
	int                      n;
	localparam int           WIN = 480;
	localparam int           PER [7] = '{4, 6, 8, 10, 12, 16, 20};

	pacd_tb_row_t rows [14] = '{
		'{1'b0, 8'h84, 32'h0, 32'h0000_0000}, '{1'b0, 8'h88, 32'h0, 32'h0000_040E},
		'{1'b0, 8'hA0, 32'h0, 32'h0000_0007}, '{1'b0, 8'hB0, 32'h0, 32'h0000_0007},
		'{1'b0, 8'hB4, 32'h0, 32'h0000_0000}, '{1'b1, 8'h84, 32'hFFFF_FFFF, 32'h077F_FFFF},
		'{1'b1, 8'h88, 32'hFFFF_FFFF, 32'h0000_07FE}, '{1'b1, 8'h88, 32'h1, 32'h0},
		'{1'b1, 8'hA0, 32'hFFFF_FFFF, 32'h0000_0007}, '{1'b1, 8'hA8, 32'hFFFF_FFF5, 32'h5},
		'{1'b1, 8'hA4, 32'h6000_000F, 32'hE000_000F}, '{1'b1, 8'hB4, 32'h4000_0002, 32'hC000_0002},
		'{1'b1, 8'hBC, 32'h8000_0000, 32'h0}, '{1'b1, 8'h90, 32'hFFFF_FFFF, 32'h0}
	};

	pacd_top pacd_top_inst (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.bus_req          (bus_req),
		.reg_rdata_ff     (reg_rdata_ff),
		.src              (src),
		.fclk_clk_en      (clk_en),
		.fclk_auto_gate   (auto_gate),
		.fclk_periph_idle (idle),
		.auto_gate_1_ff   (ag1),
		.auto_gate_2_ff   (ag2),
		.fclk_ff          (fclk)
	);

	pacd_src_model pacd_src_model_inst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.src     (src)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp32

	task automatic cmp_cnt(input int got, input int exp);
		int tol;
		tol = (exp == 0) ? 0 : 1;
		comparisons++;
		if (got < exp - tol || got > exp + tol) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_cnt

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		@(negedge clk);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata_ff;
	endtask : bus_rd

	// Enables are dropped before the source or divider changes
	task automatic set_clk(input int ch, input logic [2:0] code, input logic [3:0] d,
			input logic [31:0] ctl);
		@(posedge clk);
		clk_en[ch] <= 1'b0;
		auto_gate[ch] <= 1'b0;
		bus_wr(8'hA0 + 8'(8 * ch), {29'h0, code});
		bus_wr(8'hA4 + 8'(8 * ch), ctl | {28'h0, d});
		repeat (64) @(posedge clk);
		clk_en[ch] <= 1'b1;
	endtask : set_clk

	task automatic measure(input int ch, output int cnt);
		logic prev;
		prev = 1'b0;
		cnt = 0;
		// Let the three-stage clock path settle after the last input change
		repeat (4) @(negedge clk);
		repeat (WIN) begin
			@(negedge clk);
			if (fclk[ch] === 1'b1 && prev !== 1'b1) cnt++;
			prev = fclk[ch];
		end
	endtask : measure

	function automatic int exp_edges(input int ch, input int code, input int d);
		logic ok;
		ok = (ch == 0) ? (code inside {0, 2, 3, 5, 6}) : (code inside {0, 1, 3, 4, 5, 6});
		return ok ? WIN / PER[code] / (d + 1) : 0;
	endfunction : exp_edges

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#(4 * 60000);
		err_count++;
		close_out();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		err_count = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		bus_req = '0;
		clk_en = 4'hF;
		auto_gate = 4'h0;
		idle = 4'h0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		measure(2, n);
		cmp_cnt(n, 0);
		foreach (rows[i]) begin
			if (rows[i].wr) bus_wr(rows[i].a, rows[i].w);
			bus_rd(rows[i].a, rd_val);
			cmp32(rd_val, rows[i].e);
			if (rows[i].a == 8'h84) cmp32(ag1, rows[i].e);
			if (rows[i].a == 8'h88) cmp32(ag2, rows[i].e);
		end
		bus_wr(8'h84, 32'h0400_1001);
		cmp32({ag1.random_generator, ag1.port, ag1.pwm_one}, 32'h43);
		bus_wr(8'h88, 32'h0000_0402);
		cmp32({ag2.rom_controller, ag2.math_accelerator, ag2.ram_bank}, 32'h11);
		$display("test registers done");
		for (int ch = 0; ch < 2; ch++) begin
			for (int c = 0; c < 8; c++) begin
				set_clk(ch, 3'(c), 4'h0, 32'h0);
				measure(ch, n);
				cmp_cnt(n, exp_edges(ch, c, 0));
			end
		end
		$display("test selectors done");
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'hA4, wdata: 32'h5};
		@(posedge clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: 8'hA4, wdata: 32'h0};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		cmp32(reg_rdata_ff, 32'h8000_0005);
		set_clk(1, 3'h0, 4'h0, 32'h0);
		bus_wr(8'hAC, 32'h3);
		bus_rd(8'hAC, rd_val);
		cmp32(rd_val, 32'h8000_0003);
		repeat (200) @(posedge clk);
		bus_rd(8'hAC, rd_val);
		cmp32(rd_val, 32'h0000_0003);
		measure(1, n);
		cmp_cnt(n, exp_edges(1, 0, 3));
		set_clk(1, 3'h0, 4'hF, 32'h0);
		measure(1, n);
		cmp_cnt(n, exp_edges(1, 0, 15));
		$display("test divider done");
		set_clk(3, 3'h6, 4'h1, 32'h0);
		measure(3, n);
		cmp_cnt(n, exp_edges(3, 6, 1));
		@(posedge clk);
		clk_en[3] <= 1'b0;
		measure(3, n);
		cmp_cnt(n, 0);
		@(posedge clk);
		clk_en[3] <= 1'b1;
		auto_gate[3] <= 1'b1;
		idle[3] <= 1'b1;
		measure(3, n);
		cmp_cnt(n, 0);
		@(posedge clk);
		idle[3] <= 1'b0;
		measure(3, n);
		cmp_cnt(n, exp_edges(3, 6, 1));
		set_clk(3, 3'h6, 4'h1, 32'h4000_0000);
		measure(3, n);
		cmp_cnt(n, 0);
		set_clk(3, 3'h6, 4'h1, 32'h2000_0000);
		measure(3, n);
		cmp_cnt(n, 0);
		set_clk(3, 3'h6, 4'h1, 32'h0);
		measure(3, n);
		cmp_cnt(n, exp_edges(3, 6, 1));
		$display("test gating done");
		bus_wr(8'hB0, 32'h0);
		bus_wr(8'h88, 32'h0);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		bus_rd(8'hB0, rd_val);
		cmp32(rd_val, 32'h7);
		bus_rd(8'h88, rd_val);
		cmp32(rd_val, 32'h0000_040E);
		$display("test second reset done");
		close_out();
	end
endmodule : testbench
